// ===== src/psfc_regs.sv
// Sleep force and PCI-domain configuration register bank
// Behaviour
// RL1: Writing one to bit0 forces sleep
// RL2: Writing one to bit1 forces wake
// RL3: Gated warm reset restores cold values
// RL4: Clock select and clock-run ignore warm reset
// RL5: Clock select cold zero, EEPROM overwrites
// RL6: Clock select picks reference or external
// RL7: Clock-run cold zero, EEPROM overwrites
// RL8: Clock-run zero keeps host clock running
// RL9: Association status bits 6:5 drive LEDs
// RL10: Bits 9:7 select observation bus mux
// RL11: Bit 10 disables byte-enable fix
// RL12: Bit 11 allows interrupt while asleep
// RL13: Registers at 0x400c and 0x4010, read/write
// RL14: Reserved bits hold nothing, read zero
// RL15: Warm bit self-clears after 64 clocks
// RL16: Force bits pulse, read zero, both wake
`timescale 1ns/10ps
`default_nettype none
module psfc_regs #(
    parameter int ADDR_W = 16
) (
    // Clock and resets
    input  wire logic              CLK,
    input  wire logic              SYS_RST,
    input  wire logic              WARM_RST,
    // Register access from the PCI target
    input  wire logic              REG_WR,
    input  wire logic              REG_RD,
    input  wire logic [ADDR_W-1:0] REG_ADDR,
    input  wire logic [31:0]       REG_WDATA,
    output logic      [31:0]       REG_RDATA,
    output logic                   REG_RVALID,
    // Reset control warm-reset bit write
    input  wire logic              RC_WR,
    input  wire logic [31:0]       RC_WDATA,
    output logic                   RC_PCI_WARM,
    // EEPROM load
    input  wire logic              EE_LOAD,
    input  wire logic              EE_SLEEP_CLK_SEL,
    input  wire logic              EE_CLOCK_RUN_PERMIT,
    // Sleep clock inputs
    input  wire logic              RADIO_REFERENCE_CLOCK,
    input  wire logic              EXT_SLEEP_CLK,
    // Controls to the MAC
    output logic                   SLEEP_ENTER,
    output logic                   SLEEP_EXIT,
    output logic                   SLEEP_CLK,
    output logic                   SLEEP_CLK_SEL,
    output logic                   CLOCK_RUN_PERMIT,
    output logic [1:0]             ASSOC_STATUS,
    output logic [2:0]             OBS_MUX_SEL,
    output logic                   CBE_FIX_DISABLE,
    output logic                   INT_IN_SLEEP_EN
);
    logic       pci_warm;
    logic       sclk;
    logic       crun;
    logic [1:0] assoc;
    logic [2:0] obs;
    logic       cbe;
    logic       ints;

    // Address decode
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] off);
        hit = (a == ADDR_W'(off));
    endfunction : hit

    wire sfc_sel = hit(REG_ADDR, psfc_pkg::SFC_OFFSET); // RL13
    wire cfg_sel = hit(REG_ADDR, psfc_pkg::CFG_OFFSET); // RL13
    wire cfg_wr  = REG_WR && cfg_sel;
    wire sfc_wr  = REG_WR && sfc_sel;
    wire warm_clr = WARM_RST && pci_warm; // RL3

    // Force pulses; exit wins when both set
    wire next_exit  = sfc_wr && REG_WDATA[psfc_pkg::SFC_EXIT_BIT]; // RL2 RL16
    wire next_enter = sfc_wr && REG_WDATA[psfc_pkg::SFC_ENTER_BIT]
                      && !REG_WDATA[psfc_pkg::SFC_EXIT_BIT]; // RL1 RL16

    // Read data; force register and reserved bits read zero
    wire [31:0] cfg_view = {20'h00000, ints, cbe, obs, assoc, 2'h0, crun, sclk, 1'h0}; // RL14
    wire [31:0] next_rdata = (REG_RD && cfg_sel) ? cfg_view : 32'h00000000; // RL14 RL16

    // Warm-reset bit with self-clear
    psfc_warm_gate u_warm (
        .CLK      (CLK),
        .SYS_RST  (SYS_RST),
        .wr_en    (RC_WR),
        .wr_bit   (RC_WDATA[psfc_pkg::RC_PCI_BIT]),
        .pci_warm (pci_warm)
    );

    // Clock select and clock-run: cold reset, EEPROM, write; no warm reset
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            sclk <= psfc_pkg::SCLK_RST; // RL5
            crun <= psfc_pkg::CRUN_RST; // RL7
        end else if (EE_LOAD) begin
            sclk <= EE_SLEEP_CLK_SEL; // RL5
            crun <= EE_CLOCK_RUN_PERMIT; // RL7
        end else if (cfg_wr) begin // RL4
            sclk <= REG_WDATA[psfc_pkg::CFG_SCLK_BIT];
            crun <= REG_WDATA[psfc_pkg::CFG_CRUN_BIT];
        end
    end

    // Remaining fields: cold reset or gated warm reset
    always_ff @(posedge CLK) begin
        if (SYS_RST || warm_clr) begin // RL3
            assoc <= psfc_pkg::ASSOC_RST; // RL9
            obs   <= psfc_pkg::OBS_RST; // RL10
            cbe   <= psfc_pkg::CBE_RST; // RL11
            ints  <= psfc_pkg::INTS_RST; // RL12
        end else if (cfg_wr) begin
            assoc <= REG_WDATA[psfc_pkg::CFG_ASSOC_LO +: psfc_pkg::ASSOC_W]; // RL9
            obs   <= REG_WDATA[psfc_pkg::CFG_OBS_LO +: psfc_pkg::OBS_W]; // RL10
            cbe   <= REG_WDATA[psfc_pkg::CFG_CBE_BIT]; // RL11
            ints  <= REG_WDATA[psfc_pkg::CFG_INTS_BIT]; // RL12
        end
    end

    // Registered outputs
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            SLEEP_ENTER      <= 1'h0;
            SLEEP_EXIT       <= 1'h0;
            SLEEP_CLK        <= 1'h0;
            REG_RDATA        <= 32'h00000000;
            REG_RVALID       <= 1'h0;
            SLEEP_CLK_SEL    <= psfc_pkg::SCLK_RST;
            CLOCK_RUN_PERMIT <= psfc_pkg::CRUN_RST;
            ASSOC_STATUS     <= psfc_pkg::ASSOC_RST;
            OBS_MUX_SEL      <= psfc_pkg::OBS_RST;
            CBE_FIX_DISABLE  <= psfc_pkg::CBE_RST;
            INT_IN_SLEEP_EN  <= psfc_pkg::INTS_RST;
            RC_PCI_WARM      <= psfc_pkg::RC_PCI_RST;
        end else begin
            SLEEP_ENTER      <= next_enter && !warm_clr; // RL1
            SLEEP_EXIT       <= next_exit && !warm_clr; // RL2
            SLEEP_CLK        <= sclk ? EXT_SLEEP_CLK : RADIO_REFERENCE_CLOCK; // RL6
            REG_RDATA        <= next_rdata;
            REG_RVALID       <= REG_RD;
            SLEEP_CLK_SEL    <= sclk;
            CLOCK_RUN_PERMIT <= crun; // RL8
            ASSOC_STATUS     <= assoc;
            OBS_MUX_SEL      <= obs;
            CBE_FIX_DISABLE  <= cbe;
            INT_IN_SLEEP_EN  <= ints;
            RC_PCI_WARM      <= pci_warm;
        end
    end

    // Exit beats enter on a both-ones write
    both_exit_a: assert property (@(posedge CLK) disable iff (SYS_RST) // RL16
        sfc_wr && !warm_clr && REG_WDATA[1:0] == 2'h3 |=> SLEEP_EXIT && !SLEEP_ENTER)
        else $error("Both-ones write did not exit");
    enter_pulse_a: assert property (@(posedge CLK) disable iff (SYS_RST) // RL1
        SLEEP_ENTER |=> !SLEEP_ENTER || $past(next_enter))
        else $error("Enter pulse stuck");
    zero_noeffect_a: assert property (@(posedge CLK) disable iff (SYS_RST) // RL2
        sfc_wr && REG_WDATA[1:0] == 2'h0 |=> !SLEEP_EXIT && !SLEEP_ENTER)
        else $error("Zero write forced state");
    warm_clear_a: assert property (@(posedge CLK) disable iff (SYS_RST) // RL3
        warm_clr |=> ##1 ASSOC_STATUS == 2'h0 && OBS_MUX_SEL == 3'h0 && !INT_IN_SLEEP_EN)
        else $error("Gated warm reset missed");
    warm_keep_a: assert property (@(posedge CLK) disable iff (SYS_RST) // RL4
        WARM_RST && !cfg_wr && !EE_LOAD |=> $stable(sclk) && $stable(crun))
        else $error("Warm reset touched clock bits");
    ungated_a: assert property (@(posedge CLK) disable iff (SYS_RST) // RL3
        WARM_RST && !pci_warm && !cfg_wr |=> $stable(assoc) && $stable(obs))
        else $error("Ungated warm reset cleared fields");
    ee_load_a: assert property (@(posedge CLK) disable iff (SYS_RST) // RL5
        EE_LOAD |=> ##1 SLEEP_CLK_SEL == $past(EE_SLEEP_CLK_SEL, 2)
                        && CLOCK_RUN_PERMIT == $past(EE_CLOCK_RUN_PERMIT, 2))
        else $error("EEPROM load not taken");
    read_zero_a: assert property (@(posedge CLK) disable iff (SYS_RST) // RL14
        REG_RVALID |-> REG_RDATA[31:12] == 20'h00000 && REG_RDATA[4:3] == 2'h0 && !REG_RDATA[0])
        else $error("Reserved bits read nonzero");
    cfg_read_a: assert property (@(posedge CLK) disable iff (SYS_RST) // RL13
        REG_RD && cfg_sel |=> REG_RVALID && REG_RDATA[10:5] == {$past(cbe), $past(obs), $past(assoc)})
        else $error("Configuration readback wrong");
    // Single-bit force writes land as one pulse of the matching kind
    enter_write_a: assert property (@(posedge CLK) disable iff (SYS_RST) // RL1
        sfc_wr && !warm_clr && REG_WDATA[1:0] == 2'h1 |=> SLEEP_ENTER && !SLEEP_EXIT)
        else $error("Enter write gave no enter pulse");
    exit_write_a: assert property (@(posedge CLK) disable iff (SYS_RST) // RL2
        sfc_wr && !warm_clr && REG_WDATA[1:0] == 2'h2 |=> SLEEP_EXIT && !SLEEP_ENTER)
        else $error("Exit write gave no exit pulse");
    // A gated warm reset swallows any force write in the same cycle
    warm_force_a: assert property (@(posedge CLK) disable iff (SYS_RST) // RL16
        warm_clr |=> !SLEEP_ENTER && !SLEEP_EXIT)
        else $error("Force pulse during warm reset");
    // Configuration writes reach the outputs two edges later
    cfg_write_a: assert property (@(posedge CLK) disable iff (SYS_RST) // RL9 RL10 RL11 RL12
        cfg_wr && !warm_clr |=> ##1
            ASSOC_STATUS == $past(REG_WDATA[psfc_pkg::CFG_ASSOC_LO +: psfc_pkg::ASSOC_W], 2)
            && OBS_MUX_SEL == $past(REG_WDATA[psfc_pkg::CFG_OBS_LO +: psfc_pkg::OBS_W], 2)
            && CBE_FIX_DISABLE == $past(REG_WDATA[psfc_pkg::CFG_CBE_BIT], 2)
            && INT_IN_SLEEP_EN == $past(REG_WDATA[psfc_pkg::CFG_INTS_BIT], 2))
        else $error("Configuration write not applied");
    // Clock bits follow a bus write unless an EEPROM load claims the cycle
    clk_write_a: assert property (@(posedge CLK) disable iff (SYS_RST) // RL4
        cfg_wr && !EE_LOAD |=> sclk == $past(REG_WDATA[psfc_pkg::CFG_SCLK_BIT])
                               && crun == $past(REG_WDATA[psfc_pkg::CFG_CRUN_BIT]))
        else $error("Clock bits not written");
    // Writes elsewhere leave the configuration alone
    stray_write_a: assert property (@(posedge CLK) disable iff (SYS_RST) // RL13
        REG_WR && !cfg_sel && !EE_LOAD && !warm_clr |=> $stable(sclk) && $stable(crun)
            && $stable(assoc) && $stable(obs) && $stable(cbe) && $stable(ints))
        else $error("Stray write changed configuration");
    // Read answer timing and idle read data
    read_valid_a: assert property (@(posedge CLK) disable iff (SYS_RST) // RL13
        REG_RD |=> REG_RVALID)
        else $error("Read not answered");
    idle_read_a: assert property (@(posedge CLK) disable iff (SYS_RST) // RL14
        !REG_RD |=> !REG_RVALID && REG_RDATA == 32'h00000000)
        else $error("Read data without a read");
    sfc_read_a: assert property (@(posedge CLK) disable iff (SYS_RST) // RL16
        REG_RD && sfc_sel |=> REG_RDATA == 32'h00000000)
        else $error("Force register read nonzero");
    // Sleep clock follows the selected source
    ext_clk_a: assert property (@(posedge CLK) disable iff (SYS_RST) // RL6
        sclk |=> SLEEP_CLK == $past(EXT_SLEEP_CLK))
        else $error("External sleep clock not selected");
    ref_clk_a: assert property (@(posedge CLK) disable iff (SYS_RST) // RL6
        !sclk |=> SLEEP_CLK == $past(RADIO_REFERENCE_CLOCK))
        else $error("Reference clock not selected");
endmodule : psfc_regs
`default_nettype wire

// ===== src/psfc_pkg.sv
// Constants shared by the sleep force and configuration register bank
package psfc_pkg;
    // Register offsets
    localparam logic [15:0] SFC_OFFSET    = 16'h400c;
    localparam logic [15:0] CFG_OFFSET    = 16'h4010;
    // Sleep force field positions
    localparam int          SFC_ENTER_BIT = 0;
    localparam int          SFC_EXIT_BIT  = 1;
    // Configuration field positions
    localparam int          CFG_SCLK_BIT  = 1;
    localparam int          CFG_CRUN_BIT  = 2;
    localparam int          CFG_ASSOC_LO  = 5;
    localparam int          CFG_OBS_LO    = 7;
    localparam int          CFG_CBE_BIT   = 10;
    localparam int          CFG_INTS_BIT  = 11;
    // Field widths
    localparam int          ASSOC_W       = 2;
    localparam int          OBS_W         = 3;
    // Reset values
    localparam logic        SCLK_RST      = 1'h0;
    localparam logic        CRUN_RST      = 1'h0;
    localparam logic [1:0]  ASSOC_RST     = 2'h0;
    localparam logic [2:0]  OBS_RST       = 3'h0;
    localparam logic        CBE_RST       = 1'h0;
    localparam logic        INTS_RST      = 1'h0;
    // Warm reset bit of the reset control register and its self-clear time
    localparam int          RC_PCI_BIT    = 4;
    localparam logic        RC_PCI_RST    = 1'h0;
    localparam int          RC_CLEAR_CLKS = 64;
    localparam logic [6:0]  RC_CNT_LAST   = 7'(RC_CLEAR_CLKS - 1);
    // Association status codes
    typedef enum logic [1:0] {
        PSFC_ASSOC_IDLE   = 2'h0,
        PSFC_ASSOC_TRYING = 2'h1,
        PSFC_ASSOC_DONE   = 2'h2,
        PSFC_ASSOC_RSVD   = 2'h3
    } psfc_assoc_e;
endpackage : psfc_pkg

// ===== src/psfc_warm_gate.sv
// Reset control warm-reset bit with 64 clock self-clear
`timescale 1ns/10ps
`default_nettype none
module psfc_warm_gate (
    // Clock and reset
    input  wire logic CLK,
    input  wire logic SYS_RST,
    // Write of the reset control register
    input  wire logic wr_en,
    input  wire logic wr_bit,
    // Bit state
    output logic      pci_warm
);
    logic [6:0] cnt;
    wire        done = pci_warm && (cnt == psfc_pkg::RC_CNT_LAST);

    // Bit is set by software and cleared after 64 clocks
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            pci_warm <= psfc_pkg::RC_PCI_RST;
            cnt      <= 7'h00;
        end else if (wr_en) begin
            pci_warm <= wr_bit;
            cnt      <= 7'h00;
        end else begin
            pci_warm <= pci_warm && !done; // RL15
            cnt      <= pci_warm ? cnt + 7'h01 : 7'h00;
        end
    end

    // Bit still set eight cycles after it rises when no write follows
    rc_clear_a: assert property (@(posedge CLK) disable iff (SYS_RST) // RL15
        $rose(pci_warm) && !wr_en ##1 (!wr_en) [*8] |-> pci_warm)
        else $error("Warm bit cleared early");
endmodule : psfc_warm_gate
`default_nettype wire

// ===== verif/psfc_host.sv
// Host model that issues register and reset control accesses
`timescale 1ns/10ps
`default_nettype none
module psfc_host (
    // Clock
    input  wire logic        clk,
    // Register access
    output var  logic        wr,
    output var  logic        rd,
    output var  logic [15:0] addr,
    output var  logic [31:0] wdata,
    input  wire logic [31:0] rdata,
    input  wire logic        rvalid,
    // Reset control access
    output var  logic        rc_wr,
    output var  logic [31:0] rc_wdata
);
    // Idle bus at time zero
    initial begin
        {wr, rd, rc_wr, addr, wdata, rc_wdata} = '0;
    end
    // One write cycle; released lines show the inverse so stale data is not trusted
    task automatic wr_reg(input logic [15:0] a, input logic [31:0] d, input logic rc);
        @(posedge clk);
        wr       <= ~rc;
        rc_wr    <= rc;
        addr     <= a;
        wdata    <= d;
        rc_wdata <= d;
        @(posedge clk);
        {wr, rc_wr} <= 2'h0;
        addr     <= ~a;
        wdata    <= ~d;
        rc_wdata <= ~d;
    endtask : wr_reg
    // One read cycle, data taken with its valid flag
    task automatic rd_reg(input logic [15:0] a, output logic [31:0] d, output logic v);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd   <= 1'b0;
        addr <= ~a;
        #1;
        d = rdata;
        v = rvalid;
    endtask : rd_reg
endmodule : psfc_host
`default_nettype wire

// ===== verif/pci_sleep_force_and_config_regs_test.sv
// Self-checking bench for the sleep force and configuration registers
`timescale 1ns/10ps
`default_nettype none
module pci_sleep_force_and_config_regs_test;
    logic        clk = 1'b0, sys_rst = 1'b1, warm_rst = 1'b0;
    logic        ee_load = 1'b0, ee_sel = 1'b0, ee_crun = 1'b0;
    logic        wr, rd, rc_wr, rvalid, rc_warm, s_enter, s_exit, s_clk, s_sel, crun, cbe, ints, v;
    logic [15:0] addr;
    logic [31:0] wdata, rdata, rc_wdata, d;
    logic [1:0]  assoc;
    logic [2:0]  obs;
    int          error_cnt = 0, cmp_count = 0, cyc = 0;
    // Clock never stopped by the host
    always #4 clk = ~clk;
    psfc_host u_host (.clk(clk), .wr(wr), .rd(rd), .addr(addr), .wdata(wdata), .rdata(rdata),
        .rvalid(rvalid), .rc_wr(rc_wr), .rc_wdata(rc_wdata));
    psfc_regs u_dut (.CLK(clk), .SYS_RST(sys_rst), .WARM_RST(warm_rst), .REG_WR(wr),
        .REG_RD(rd), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata),
        .REG_RVALID(rvalid), .RC_WR(rc_wr), .RC_WDATA(rc_wdata), .RC_PCI_WARM(rc_warm),
        .EE_LOAD(ee_load), .EE_SLEEP_CLK_SEL(ee_sel), .EE_CLOCK_RUN_PERMIT(ee_crun),
        .RADIO_REFERENCE_CLOCK(1'b0), .EXT_SLEEP_CLK(1'b1), .SLEEP_ENTER(s_enter),
        .SLEEP_EXIT(s_exit), .SLEEP_CLK(s_clk), .SLEEP_CLK_SEL(s_sel),
        .CLOCK_RUN_PERMIT(crun), .ASSOC_STATUS(assoc), .OBS_MUX_SEL(obs),
        .CBE_FIX_DISABLE(cbe), .INT_IN_SLEEP_EN(ints));
    // Compare and count
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Verdict and end of run
    task automatic results;
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results
    // Let n edges pass and settle
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // Force write then pulse check
    task automatic force_chk(input logic [31:0] d_in, input logic [1:0] exp);
        u_host.wr_reg(psfc_pkg::SFC_OFFSET, d_in, 1'b0);
        #1;
        chk({s_enter, s_exit}, exp);
        tick(1);
        chk({s_enter, s_exit}, 2'h0);
    endtask : force_chk
    // One-edge warm reset pulse
    task automatic warm_pulse;
        @(posedge clk) warm_rst <= 1'b1;
        @(posedge clk) warm_rst <= 1'b0;
    endtask : warm_pulse
    // One-edge EEPROM load pulse
    task automatic ee_pulse;
        @(posedge clk) ee_load <= 1'b1;
        @(posedge clk) ee_load <= 1'b0;
    endtask : ee_pulse
    // Hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            error_cnt++;
            results();
        end
    end
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        u_host.rd_reg(psfc_pkg::CFG_OFFSET, d, v);
        chk({v, d}, 33'h100000000);
        chk({s_sel, crun, assoc, obs, cbe, ints}, 10'h0);
        force_chk(32'h1, 2'h2);
        force_chk(32'h2, 2'h1);
        force_chk(32'h3, 2'h1);
        force_chk(32'h0, 2'h0);
        u_host.wr_reg(psfc_pkg::CFG_OFFSET, 32'hffffffff, 1'b0);
        tick(2);
        chk({s_sel, crun, assoc, obs, cbe, ints}, 9'h1ff);
        u_host.rd_reg(psfc_pkg::CFG_OFFSET, d, v);
        chk(d, 32'hfe6);
        u_host.rd_reg(psfc_pkg::SFC_OFFSET, d, v);
        chk(d, 32'h0);
        u_host.rd_reg(16'h4000, d, v);
        chk(d, 32'h0);
        tick(8);
        chk(s_clk, 1'b1);
        warm_pulse();
        u_host.rd_reg(psfc_pkg::CFG_OFFSET, d, v);
        chk(d, 32'hfe6);
        u_host.wr_reg(16'h4000, 32'h10, 1'b1);
        tick(1);
        chk(rc_warm, 1'b1);
        warm_pulse();
        u_host.rd_reg(psfc_pkg::CFG_OFFSET, d, v);
        chk(d, 32'h6);
        tick(2);
        chk({cbe, ints, assoc, obs}, 7'h0);
        fork
            warm_pulse();
            u_host.wr_reg(psfc_pkg::CFG_OFFSET, 32'hffffffff, 1'b0);
        join
        tick(2);
        chk({s_sel, crun, assoc, obs, cbe, ints}, 9'h180);
        fork
            warm_pulse();
            force_chk(32'h1, 2'h0);
        join
        tick(50);
        chk(rc_warm, 1'b1);
        tick(1);
        chk(rc_warm, 1'b0);
        ee_crun <= 1'b1;
        fork
            ee_pulse();
            u_host.wr_reg(psfc_pkg::CFG_OFFSET, 32'h2, 1'b0);
        join
        u_host.rd_reg(psfc_pkg::CFG_OFFSET, d, v);
        chk(d, 32'h4);
        tick(8);
        chk({s_clk, crun}, 2'h1);
        results();
    end
endmodule : pci_sleep_force_and_config_regs_test
`default_nettype wire
